/* File: logic/mtq_pkg.sv */
package mtq_pkg;
  // Operating modes, decoded in this order from the two-bit field
  typedef enum logic [1:0] {MTQ_PER, MTQ_PWM, MTQ_OS, MTQ_CAP} mtq_mode_t;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL1 = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_PRS = 8'h08;
  localparam logic [7:0] OFS_GRA = 8'h0C;
  localparam logic [7:0] OFS_GRB = 8'h10;
  localparam logic [7:0] OFS_CNT = 8'h14;
  localparam logic [7:0] OFS_SR = 8'h18;
  localparam logic [7:0] OFS_GEC = 8'h20;
  localparam logic [7:0] OFS_QA = 8'h24;
  localparam logic [7:0] OFS_QB = 8'h28;
  localparam logic [7:0] OFS_QPOS = 8'h2C;
  localparam logic [7:0] OFS_QREV = 8'h30;
  // Control one fields
  localparam int C1_CSEL = 2;
  localparam int C1_LVL = 7;
  localparam int C1_ADC = 8;
  // Control two fields
  localparam int C2_RUN = 0;
  localparam int C2_CLR = 1;
  // Status fields
  localparam int SR_OVF = 0;
  localparam int SR_MFB = 1;
  localparam int SR_MFA = 2;
  localparam int SR_UA = 4;
  localparam int SR_UB = 5;
  localparam int SR_REV = 8;
  localparam int SR_DCH = 9;
  localparam int SR_DIR = 10;
  // Capture clear select codes
  localparam logic [1:0] CLR_RISE = 2'h0;
  localparam logic [1:0] CLR_FALL = 2'h1;
  localparam logic [1:0] CLR_BOTH = 2'h2;
  // Timing counts in peripheral clock cycles
  localparam logic [1:0] ADC_TRIG_CYC = 2'h3;
  localparam int CAP_DLY_CYC = 5;
  // Reset values
  localparam logic [15:0] RST_H = 16'h0000;
  localparam logic [9:0] RST_PRS = 10'h000;
endpackage : mtq_pkg

/* File: logic/mtq_timer.sv */
`timescale 1ns/1ns
module mtq_timer
  import mtq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic timer_io_i,
  output logic timer_io_o,
  output logic timer_io_oe_n_o,
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  input wire logic phase_z_i,
  output logic adc_trig_o
);

  // Whole block state in one record
  typedef struct packed {
    logic ack; // Bus answer
    logic [31:0] dat; // Read data
    mtq_mode_t mode; // Operating mode
    logic [1:0] csel; // Capture clear select
    logic lvl; // Output initial level
    logic adc_en; // ADC trigger enable
    logic run; // Timer run enable
    logic [9:0] prs; // Prescale setting
    logic [9:0] psc; // Prescale counter
    logic [15:0] compare_reg_a; // Compare register A
    logic [15:0] compare_reg_b; // Compare register B
    logic [15:0] cnt; // Current count value
    logic [15:0] bufa; // Compare buffer 0
    logic [15:0] bufb; // Compare buffer 1
    logic mfa; // Match A flag
    logic mfb; // Match B flag
    logic ovf; // Overflow flag
    logic rvf; // Revolution flag
    logic dcf; // Direction change flag
    logic dir; // Rotation direction
    logic uaf; // Phase A update flag
    logic ubf; // Phase B update flag
    logic qen; // Quad decoder enable
    logic out; // Pin output level
    logic [1:0] adc; // Trigger cycles left
    logic pin_q; // Previous pin sample
    logic [CAP_DLY_CYC-1:0] rd; // Rising edge delay line
    logic [CAP_DLY_CYC-1:0] fd; // Falling edge delay line
    logic pa_q; // Previous phase A
    logic pb_q; // Previous phase B
    logic pz_q; // Previous index
    logic [15:0] ia; // Phase A interval
    logic [15:0] ib; // Phase B interval
    logic [15:0] la; // Latest A
    logic [15:0] lap; // Previous A
    logic [15:0] lb; // Latest B
    logic [15:0] lbp; // Previous B
    logic [15:0] pos; // Position count
    logic [15:0] pst; // Position at last index
    logic [15:0] rev; // Revolution count
  } mtq_state_t;

  mtq_state_t s_r; // Registered state
  mtq_state_t s_nxt; // Next state

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] mtq_lane(input logic [15:0] o, input logic [31:0] d,
                                           input logic [3:0] sel);
    mtq_lane = {sel[1] ? d[15:8] : o[15:8], sel[0] ? d[7:0] : o[7:0]};
  endfunction : mtq_lane

  // Saturating increment for interval counters
  function automatic logic [15:0] mtq_sat(input logic [15:0] v);
    mtq_sat = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction : mtq_sat

  logic wr; // Bus write this cycle
  logic rd_req; // Bus read this cycle
  logic tick; // Prescaled counting tick
  logic ok; // Period is non-zero, or capture mode
  logic go; // Counter may advance
  logic [15:0] per; // Active period value
  logic end_p; // Period end event
  logic hit_a; // Compare A event
  logic pwm_like; // PWM or one-shot
  logic cap_r; // Delayed rising capture
  logic cap_f; // Delayed falling capture
  logic a_up; // Phase A rising
  logic b_up; // Phase B rising
  logic z_up; // Index rising
  logic [15:0] wm; // Write-one-clear mask
  logic clr; // Counter clear command this cycle
  logic [15:0] prs_w; // Prescale write merged by lane

  // Event decode shared by next-state logic and checks
  always_comb begin
    // Write lands at the edge where the master sees ack
    wr = wb_cyc_i && wb_stb_i && wb_we_i && s_r.ack;
    rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !s_r.ack;
    tick = (s_r.run || s_r.qen) && (s_r.psc == s_r.prs);
    pwm_like = (s_r.mode == MTQ_PWM) || (s_r.mode == MTQ_OS);
    per = (s_r.mode == MTQ_PER) ? s_r.bufa : s_r.bufb;
    // Zero period holds the counter off
    ok = (s_r.mode == MTQ_CAP) || (per != 16'h0000);
    go = s_r.run && ok;
    end_p = go && tick && (s_r.mode != MTQ_CAP) && (s_r.cnt == per - 16'h0001);
    hit_a = go && tick && pwm_like && (s_r.cnt == s_r.bufa - 16'h0001);
    cap_r = (s_r.mode == MTQ_CAP) && s_r.rd[CAP_DLY_CYC-1];
    cap_f = (s_r.mode == MTQ_CAP) && s_r.fd[CAP_DLY_CYC-1];
    a_up = s_r.qen && phase_a_i && !s_r.pa_q;
    b_up = s_r.qen && phase_b_i && !s_r.pb_q;
    z_up = s_r.qen && phase_z_i && !s_r.pz_q;
    wm = mtq_lane(16'h0000, wb_dat_i, wb_sel_i);
    clr = wr && (wb_adr_i == OFS_CTRL2) && wb_sel_i[0] && wb_dat_i[C2_CLR];
    prs_w = mtq_lane({6'h00, s_r.prs}, wb_dat_i, wb_sel_i);
  end

  // Next-state logic: bus first, hardware events after so sets win
  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = wb_cyc_i && wb_stb_i && !s_r.ack;
    s_nxt.dat = 32'h0000_0000;
    // Register reads, unmapped offsets read zero
    if (rd_req) begin
      case (wb_adr_i)
        OFS_CTRL1: s_nxt.dat = {23'h00_0000, s_r.adc_en, s_r.lvl, 3'h0, s_r.csel, s_r.mode};
        OFS_CTRL2: s_nxt.dat = {31'h0000_0000, s_r.run};
        OFS_PRS: s_nxt.dat = {22'h00_0000, s_r.prs};
        OFS_GRA: s_nxt.dat = {16'h0000, s_r.compare_reg_a};
        OFS_GRB: s_nxt.dat = {16'h0000, s_r.compare_reg_b};
        OFS_CNT: s_nxt.dat = {16'h0000, s_r.cnt};
        OFS_SR: s_nxt.dat = {21'h00_0000, s_r.dir, s_r.dcf, s_r.rvf, 2'h0, s_r.ubf,
                             s_r.uaf, 1'b0, s_r.mfa, s_r.mfb, s_r.ovf};
        OFS_GEC: s_nxt.dat = {31'h0000_0000, s_r.qen};
        OFS_QA: s_nxt.dat = {s_r.lap, s_r.la};
        OFS_QB: s_nxt.dat = {s_r.lbp, s_r.lb};
        OFS_QPOS: s_nxt.dat = {s_r.pst, s_r.pos};
        OFS_QREV: s_nxt.dat = {16'h0000, s_r.rev};
        default: s_nxt.dat = 32'h0000_0000;
      endcase
    end
    // Stopped timer tracks compare registers so a later start sees them
    if (!s_r.run) begin
      s_nxt.bufa = s_r.compare_reg_a;
      s_nxt.bufb = s_r.compare_reg_b;
      s_nxt.out = s_r.lvl;
    end
    // Register writes
    if (wr) begin
      case (wb_adr_i)
        OFS_CTRL1: begin
          if (wb_sel_i[0]) begin
            s_nxt.mode = mtq_mode_t'(wb_dat_i[1:0]);
            s_nxt.csel = wb_dat_i[C1_CSEL+:2];
            s_nxt.lvl = wb_dat_i[C1_LVL];
          end
          if (wb_sel_i[1]) begin
            s_nxt.adc_en = wb_dat_i[C1_ADC];
          end
        end
        OFS_CTRL2: begin
          if (wb_sel_i[0]) begin
            s_nxt.run = wb_dat_i[C2_RUN];
            // Clear command restarts and reloads buffers
            if (wb_dat_i[C2_CLR]) begin
              s_nxt.cnt = 16'h0000;
              s_nxt.psc = 10'h000;
              s_nxt.bufa = s_r.compare_reg_a;
              s_nxt.bufb = s_r.compare_reg_b;
              s_nxt.out = s_r.lvl;
            end
          end
        end
        OFS_PRS: s_nxt.prs = prs_w[9:0];
        OFS_GRA: s_nxt.compare_reg_a = mtq_lane(s_r.compare_reg_a, wb_dat_i, wb_sel_i);
        OFS_GRB: s_nxt.compare_reg_b = mtq_lane(s_r.compare_reg_b, wb_dat_i, wb_sel_i);
        OFS_CNT: s_nxt.cnt = mtq_lane(s_r.cnt, wb_dat_i, wb_sel_i);
        OFS_SR: begin
          // Write one to clear
          s_nxt.ovf = s_r.ovf && !wm[SR_OVF];
          s_nxt.mfb = s_r.mfb && !wm[SR_MFB];
          s_nxt.mfa = s_r.mfa && !wm[SR_MFA];
          s_nxt.uaf = s_r.uaf && !wm[SR_UA];
          s_nxt.ubf = s_r.ubf && !wm[SR_UB];
          s_nxt.rvf = s_r.rvf && !wm[SR_REV];
          s_nxt.dcf = s_r.dcf && !wm[SR_DCH];
        end
        OFS_GEC: if (wb_sel_i[0]) s_nxt.qen = wb_dat_i[0];
        default: s_nxt.qen = s_nxt.qen;
      endcase
    end
    // Prescaler divides the reference clock
    // Clear command wins over a tick for prescaler and count, not for period end or match A events
    if ((s_r.run || s_r.qen) && !clr) begin
      s_nxt.psc = tick ? 10'h000 : s_r.psc + 10'h001;
    end
    // Counting on each tick, from zero upward
    if (go && tick && !clr) begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
      if (s_r.mode == MTQ_CAP && s_r.cnt == 16'hFFFF) begin
        s_nxt.ovf = 1'b1;
      end
    end
    // Periodic: match A ends the period and toggles the pin
    if (end_p && s_r.mode == MTQ_PER) begin
      s_nxt.cnt = 16'h0000;
      s_nxt.mfa = 1'b1;
      s_nxt.out = !s_r.out;
      s_nxt.bufa = s_r.compare_reg_a;
      s_nxt.bufb = s_r.compare_reg_b;
    end
    // PWM and one-shot: width ends at match A
    if (hit_a) begin
      s_nxt.mfa = 1'b1;
      s_nxt.out = !s_r.lvl;
    end
    // PWM and one-shot: period ends at match B
    if (end_p && pwm_like) begin
      s_nxt.cnt = 16'h0000;
      s_nxt.mfb = 1'b1;
      s_nxt.out = s_r.lvl;
      s_nxt.bufa = s_r.compare_reg_a;
      s_nxt.bufb = s_r.compare_reg_b;
      if (s_r.mode == MTQ_OS) begin
        s_nxt.run = 1'b0;
      end
    end
    // ADC start pulse, counted down with no acknowledge
    if (s_r.adc != 2'h0) begin
      s_nxt.adc = s_r.adc - 2'h1;
    end
    if (s_r.adc_en && ((end_p && s_r.mode == MTQ_PER) || hit_a)) begin
      s_nxt.adc = ADC_TRIG_CYC;
    end
    // Pin edges enter a fixed delay line before capture
    s_nxt.pin_q = timer_io_i;
    s_nxt.rd = {s_r.rd[CAP_DLY_CYC-2:0], timer_io_i && !s_r.pin_q};
    s_nxt.fd = {s_r.fd[CAP_DLY_CYC-2:0], !timer_io_i && s_r.pin_q};
    // Rising edge captures into B, falling into A
    if (cap_r) begin
      s_nxt.compare_reg_b = s_r.cnt;
      s_nxt.mfb = 1'b1;
      if (s_r.csel == CLR_RISE || s_r.csel == CLR_BOTH) begin
        s_nxt.cnt = 16'h0000;
      end
    end
    if (cap_f) begin
      s_nxt.compare_reg_a = s_r.cnt;
      s_nxt.mfa = 1'b1;
      if (s_r.csel == CLR_FALL || s_r.csel == CLR_BOTH) begin
        s_nxt.cnt = 16'h0000;
      end
    end
    // Quadrature inputs; index edges are the only revolution source
    s_nxt.pa_q = phase_a_i;
    s_nxt.pb_q = phase_b_i;
    s_nxt.pz_q = phase_z_i;
    if (s_r.qen && tick) begin
      s_nxt.ia = mtq_sat(s_r.ia);
      s_nxt.ib = mtq_sat(s_r.ib);
    end
    if (a_up) begin
      s_nxt.la = s_r.ia;
      s_nxt.lap = s_r.la;
      s_nxt.ia = 16'h0000;
      s_nxt.uaf = 1'b1;
      // A rising with B low: A leads
      if (!phase_b_i) begin
        s_nxt.dir = 1'b0;
        s_nxt.dcf = s_r.dcf || s_r.dir;
      end
    end
    if (b_up) begin
      s_nxt.lb = s_r.ib;
      s_nxt.lbp = s_r.lb;
      s_nxt.ib = 16'h0000;
      s_nxt.ubf = 1'b1;
      if (!phase_a_i) begin
        s_nxt.dir = 1'b1;
        s_nxt.dcf = s_r.dcf || !s_r.dir;
      end
    end
    // Position sums A and B pulses, banked on index
    s_nxt.pos = s_r.pos + {15'h0000, a_up} + {15'h0000, b_up};
    if (z_up) begin
      s_nxt.pst = s_r.pos;
      s_nxt.pos = {15'h0000, a_up} + {15'h0000, b_up};
      s_nxt.rev = s_r.rev + 16'h0001;
      s_nxt.rvf = 1'b1;
    end
  end

  // State register, synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.mode <= MTQ_PER;
      s_r.prs <= RST_PRS;
      s_r.compare_reg_a <= RST_H;
      s_r.compare_reg_b <= RST_H;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.dat;
  assign timer_io_o = s_r.out;
  assign timer_io_oe_n_o = (s_r.mode == MTQ_CAP); // Capture listens on the pin
  assign adc_trig_o = (s_r.adc != 2'h0);

  // Checks
  AST_TRIG_WIDTH: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(adc_trig_o) |-> adc_trig_o [*3] ##1 !adc_trig_o)
    else $error("ADC trigger width is not three cycles");
  AST_ZERO_A: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_r.mode == MTQ_PER && s_r.bufa == 16'h0000 && !wr) |=> $stable(s_r.cnt))
    else $error("Periodic timer runs with zero period");
  AST_ZERO_B: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwm_like && s_r.bufb == 16'h0000 && !wr) |=> $stable(s_r.cnt))
    else $error("PWM or one-shot runs with zero period");
  AST_TICK_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
    (!tick && !wr && !cap_r && !cap_f) |=> $stable(s_r.cnt))
    else $error("Counter moved without a tick");
  AST_PER_END: assert property (@(posedge clk_i) disable iff (rst_i)
    (end_p && s_r.mode == MTQ_PER && !wr) |=> (s_r.cnt == 16'h0000 && s_r.mfa))
    else $error("Periodic match did not restart the count");
  AST_CAP_DLY: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_r.mode == MTQ_CAP && timer_io_i && !s_r.pin_q) |-> ##5 s_r.rd[CAP_DLY_CYC-1])
    else $error("Capture not taken five cycles after edge");
  AST_CAP_VAL: assert property (@(posedge clk_i) disable iff (rst_i)
    cap_r |=> (s_r.compare_reg_b == $past(s_r.cnt)))
    else $error("Rising capture did not latch the count");
  AST_PWM_LVL: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_r.mode == MTQ_PWM && go && hit_a) |=> (timer_io_o == !s_r.lvl))
    else $error("PWM width end left the active level");
  AST_DIR_CW: assert property (@(posedge clk_i) disable iff (rst_i)
    (a_up && !phase_b_i && !b_up) |=> (s_r.dir == 1'b0))
    else $error("Direction not clockwise when A leads");
  AST_REV_CNT: assert property (@(posedge clk_i) disable iff (rst_i)
    z_up |=> (s_r.rvf && s_r.rev == $past(s_r.rev) + 16'h0001))
    else $error("Index pulse missed by revolution counter");
  COV_TRIG: cover property (@(posedge clk_i) disable iff (rst_i) $rose(adc_trig_o));
  COV_OS_END: cover property (@(posedge clk_i) disable iff (rst_i)
    end_p && s_r.mode == MTQ_OS);
  COV_CAP: cover property (@(posedge clk_i) disable iff (rst_i) cap_r ##[1:20] cap_f);
  COV_DCH: cover property (@(posedge clk_i) disable iff (rst_i) $rose(s_r.dcf));

endmodule : mtq_timer

/* File: tb/mtq_far_model.sv */
`timescale 1ns/1ns
// Far side of the timer: quadrature encoder, capture pulse source, converter start input
module mtq_far_model (
  input wire logic clk_i,
  input wire logic adc_trig_i,
  output logic phase_a_o,
  output logic phase_b_o,
  output logic phase_z_o,
  output logic pin_o
);
  // Gray sequence of {A, B} for one forward step; reverse swaps the two lines
  localparam logic [1:0] QSEQ [4] = '{2'b10, 2'b11, 2'b01, 2'b00};

  // Lines start idle low; encoder outputs are push-pull, so a level simply holds
  initial begin
    phase_a_o = 1'b0;
    phase_b_o = 1'b0;
    phase_z_o = 1'b0;
    pin_o = 1'b0;
  end

  // Converter start input gives no answer: the pulse has to end on its own
  int starts = 0; // Trigger pulses seen, counted on their first cycle
  logic trig_q = 1'b0; // Previous trigger level
  always @(posedge clk_i) begin
    trig_q <= adc_trig_i;
    if (adc_trig_i && !trig_q) begin
      starts <= starts + 1;
    end
  end

  // One quadrature step; each quarter held four cycles so the timer sees it
  task automatic step(input logic ccw);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      phase_a_o <= ccw ? QSEQ[i][0] : QSEQ[i][1];
      phase_b_o <= ccw ? QSEQ[i][1] : QSEQ[i][0];
      repeat (3) @(posedge clk_i);
    end
  endtask : step

  // One index pulse on the third input
  task automatic index();
    @(posedge clk_i);
    phase_z_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    phase_z_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : index

  // Capture pulse on the pin: edges exactly w cycles apart
  task automatic pulse(input int w);
    @(posedge clk_i);
    pin_o <= 1'b1;
    repeat (w) @(posedge clk_i);
    pin_o <= 1'b0;
    @(posedge clk_i);
  endtask : pulse
endmodule : mtq_far_model

/* File: tb/tb.sv */
`timescale 1ns/1ns
// Self-checking bench for the timer block
module tb;
  import mtq_pkg::*;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack_o, io_o, io_oe_n, adc_trig_o;
  logic pa, pb, pz, ppin;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat, wb_dat_o, a, b;
  logic [31:0] exp_q [$]; // Expected read data, oldest first
  logic [31:0] msk_q [$]; // Bits that matter for each note
  string nm_q [$];
  logic [31:0] st = 32'h0000_E52A; // Xorshift state, seeded with 58666
  int err_count = 0;
  int check_count = 0;
  int hi, per, g, w;
  logic pv; // Previous pin level for edge counting
  // Reset-value read places, one unmapped among them
  localparam logic [7:0] RST_OFS [7] = '{OFS_CTRL1, OFS_PRS, OFS_GRA, OFS_CNT, OFS_SR,
                                         OFS_QREV, 8'h3C};
  // Pin level: far side drives it only while the timer's driver is off
  wire logic io_w = io_oe_n ? ppin : io_o;

  mtq_timer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_io_i(io_w), .timer_io_o(io_o),
    .timer_io_oe_n_o(io_oe_n), .phase_a_i(pa), .phase_b_i(pb), .phase_z_i(pz),
    .adc_trig_o(adc_trig_o));
  mtq_far_model far (.clk_i(clk_i), .adc_trig_i(adc_trig_o), .phase_a_o(pa),
    .phase_b_o(pb), .phase_z_o(pz), .pin_o(ppin));

  // 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Xorshift source for periods and pulse widths
  function automatic int xs();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return int'(st & 32'h7FFF_FFFF);
  endfunction : xs

  // Single comparison, counted
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    check_count++;
    if (seen !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, seen);
    end
  endtask : chk

  // Verdict and end of run
  task automatic end_sim();
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // Classic cycle: request held until ack is sampled, then dropped for one cycle
  task automatic bus(input logic we, input logic [7:0] ad, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= 4'h3;
    wb_adr <= ad;
    wb_wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) err_count++; // No answer
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, ad, d, q);
  endtask : wr

  // Read whose result the monitor compares against a note
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m,
                    input string nm);
    logic [31:0] q;
    exp_q.push_back(e);
    msk_q.push_back(m);
    nm_q.push_back(nm);
    bus(1'b0, ad, 32'h0000_0000, q);
  endtask : rd

  // Monitor: each read answer takes the oldest note
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0) begin
      chk(nm_q.pop_front(), wb_dat_o & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  // Start pulse (s=0) or pin (s=1)
  function automatic logic sig(input bit s);
    return s ? io_w : adc_trig_o;
  endfunction : sig

  // Cycles until the watched line reaches a level, bounded
  task automatic wt(input bit s, input logic lv, output int n);
    n = 0;
    while (sig(s) !== lv && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 400) err_count++; // Line stuck
  endtask : wt

  // High time and rise-to-rise period of the watched line
  task automatic meas(input bit s, output int h, output int p);
    int n;
    wt(s, 1'b0, n);
    wt(s, 1'b1, n);
    wt(s, 1'b0, h);
    wt(s, 1'b1, n);
    p = h + n;
  endtask : meas

  // Hang guard, well past the expected run length
  initial begin
    #200000;
    err_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    rst_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h3;
    wb_wdat = 32'h0000_0000;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset values, one unmapped place among them
    for (int i = 0; i < 7; i++) begin
      rd(RST_OFS[i], 32'h0000_0000, 32'hFFFF_FFFF, "reset");
    end
    // Zero period refuses to run: periodic with A zero, then PWM with B zero
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CTRL1, 32'(i));
      wr(OFS_GRA, 32'(i * 5));
      wr(OFS_GRB, 32'(5 - i * 5));
      wr(OFS_CTRL2, 32'h0000_0003);
      repeat (10) @(posedge clk_i);
      rd(OFS_CNT, 32'h0000_0000, 32'h0000_FFFF, "cnt_zero_period");
      wr(OFS_CTRL2, 32'h0000_0000);
    end
    // Periodic with converter start, prescale by two, random period
    g = 3 + xs() % 6;
    wr(OFS_CTRL1, 32'h0000_0100);
    wr(OFS_PRS, 32'h0000_0001);
    wr(OFS_GRA, 32'(g));
    wr(OFS_CTRL2, 32'h0000_0003);
    meas(1'b0, hi, per);
    chk("trig_width", 32'(hi), 32'h0000_0003);
    chk("trig_period", 32'(per), 32'(2 * g));
    chk("trig_count", 32'(far.starts > 0), 32'h0000_0001);
    rd(OFS_SR, 32'h0000_0004, 32'h0000_0004, "match_a");
    // PWM at both active levels; idle level shown before run
    for (int lv = 0; lv < 2; lv++) begin
      wr(OFS_CTRL2, 32'h0000_0000);
      wr(OFS_CTRL1, 32'h0000_0001 | 32'(lv << 7));
      wr(OFS_PRS, 32'h0000_0000);
      wr(OFS_GRA, 32'h0000_0003);
      wr(OFS_GRB, 32'h0000_0008);
      chk("idle_level", 32'(io_w), 32'(lv));
      wr(OFS_CTRL2, 32'h0000_0003);
      meas(1'b1, hi, per);
      chk("pwm_high", 32'(hi), lv ? 32'h0000_0003 : 32'h0000_0005);
      chk("pwm_period", 32'(per), 32'h0000_0008);
    end
    // One-shot: exactly one pulse, then the count stops
    wr(OFS_CTRL2, 32'h0000_0000);
    wr(OFS_CTRL1, 32'h0000_0002);
    wr(OFS_GRA, 32'h0000_0002);
    wr(OFS_GRB, 32'h0000_0004);
    wr(OFS_CTRL2, 32'h0000_0003);
    hi = 0;
    pv = io_w;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk_i);
      hi += (io_w === 1'b1 && pv !== 1'b1) ? 1 : 0;
      pv = io_w;
    end
    chk("os_pulses", 32'(hi), 32'h0000_0001);
    rd(OFS_CNT, 32'h0000_0000, 32'h0000_FFFF, "os_stop");
    // Capture, no clear: both edges latch, gap equals the random pulse width
    wr(OFS_CTRL2, 32'h0000_0000);
    wr(OFS_CTRL1, 32'h0000_000F);
    wr(OFS_CTRL2, 32'h0000_0003);
    chk("cap_release", 32'(io_oe_n), 32'h0000_0001);
    w = 10 + xs() % 30;
    far.pulse(w);
    repeat (10) @(posedge clk_i);
    bus(1'b0, OFS_GRA, 32'h0000_0000, a);
    bus(1'b0, OFS_GRB, 32'h0000_0000, b);
    chk("cap_gap", (a - b) & 32'h0000_FFFF, 32'(w));
    // Rising clear: the falling capture counts only from the rise
    wr(OFS_CTRL1, 32'h0000_0003);
    far.pulse(w);
    repeat (10) @(posedge clk_i);
    bus(1'b0, OFS_GRA, 32'h0000_0000, a);
    chk("cap_rise_clear", 32'(a <= 32'(w)), 32'h0000_0001);
    // Quadrature: forward, reverse, then one index
    wr(OFS_CTRL2, 32'h0000_0000);
    wr(OFS_GEC, 32'h0000_0001);
    wr(OFS_CTRL2, 32'h0000_0003);
    repeat (2) far.step(1'b0);
    rd(OFS_SR, 32'h0000_0000, 32'h0000_0400, "dir_fwd");
    repeat (2) far.step(1'b1);
    rd(OFS_SR, 32'h0000_0600, 32'h0000_0600, "dir_rev");
    far.index();
    rd(OFS_QREV, 32'h0000_0001, 32'h0000_FFFF, "rev_count");
    rd(OFS_SR, 32'h0000_0100, 32'h0000_0100, "rev_flag");
    rd(OFS_QPOS, 32'h0008_0000, 32'hFFFF_0000, "pos_at_index");
    repeat (4) @(posedge clk_i);
    end_sim();
  end
endmodule : tb
